// [core/ddc_decimation_rate_select.sv]
// Decimation chain and ratio selector for one down-converter channel, with AHB-Lite registers.
//
// Notes on behaviour
// - Primary code 011 uses half-band one only, ratio 1 with real output, else 2.
// - Code 100 cascades half-band one and third-band, ratio 3 or 6.
// - Code 101 cascades half-bands one, two and third-band, ratio 6 or 12.
// - Code 110 cascades half-bands one to three and third-band, ratio 12 real.
// - Code 110 with complex output decimates by 24 through that cascade.
// - Half-bands one to four in cascade give ratio 8 real, 16 complex.
// - Primary code 111 takes chain and ratio from secondary selector bits 7:4.
// - Secondary selector is ignored unless primary selector equals 111.
// - A secondary code cascades third-band with half-bands four to one, 48 or 24.
// - A secondary code cascades fifth-band with half-band one, ratio 10 or 5.
// - A secondary code cascades fifth-band with half-bands two, one, ratio 20 or 10.
// - A secondary code cascades fifth-band with half-bands three to one, 40 or 20.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps

module ddc_decimation_rate_select #(
  parameter int DATA_W = 16
) (
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  input  wire logic                          HSEL,
  input  wire logic [31:0]                   HADDR,
  input  wire logic [1:0]                    HTRANS,
  input  wire logic                          HWRITE,
  input  wire logic [2:0]                    HSIZE,
  input  wire logic                          HREADY,
  input  wire logic [31:0]                   HWDATA,
  output logic      [31:0]                   HRDATA,
  output logic                               HREADYOUT,
  output logic                               HRESP,
  input  wire logic                          SAMPLE_VALID,
  input  wire logic [DATA_W-1:0]             SAMPLE_DATA,
  output logic                               OUT_VALID,
  output logic      [DATA_W-1:0]             OUT_DATA,
  output logic      [ddc_decim_pkg::STAGE_W-1:0] STAGE_ENABLE,
  output logic      [ddc_decim_pkg::RATIO_W-1:0] DECIM_RATIO
);
  import ddc_decim_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [REG_W-1:0]   primary;
    logic [REG_W-1:0]   secondary;
    logic               dp_write;
    reg_sel_t           dp_sel;
    logic [31:0]        rdata;
    ratio_t             count;
    logic               out_valid;
    logic [DATA_W-1:0]  out_data;
  } state_t;

  state_t     st_r;
  state_t     st_nxt;
  stage_t     stages;
  ratio_t     ratio_full;
  ratio_t     ratio;
  logic [2:0] prim_sel;
  logic [3:0] sec_sel;
  logic       c2r_en;
  logic       addr_phase;
  reg_sel_t   ap_sel;
  logic [REG_W-1:0] prim_view;
  logic [REG_W-1:0] sec_view;

  assign prim_sel = st_r.primary[PRIM_SEL_LSB +: PRIM_SEL_W];
  assign sec_sel  = st_r.secondary[SEC_SEL_LSB +: SEC_SEL_W];
  assign c2r_en   = st_r.primary[C2R_BIT];

  // ==========================================================================
  // Chain resolution
  // ==========================================================================
  always_comb
  begin
    stages     = STG_HB1 | STG_HB2;
    ratio_full = RATIO_HB12;
    case (prim_sel)
      PRIM_HB12:
      begin
        stages     = STG_HB1 | STG_HB2;
        ratio_full = RATIO_HB12;
      end
      PRIM_HB123:
      begin
        stages     = STG_HB1 | STG_HB2 | STG_HB3;
        ratio_full = RATIO_HB123;
      end
      PRIM_HB1234:
      begin
        stages     = STG_HB1 | STG_HB2 | STG_HB3 | STG_HB4;
        ratio_full = RATIO_HB1234;
      end
      PRIM_HB1:
      begin
        stages     = STG_HB1;
        ratio_full = RATIO_HB1;
      end
      PRIM_HB1_TB:
      begin
        stages     = STG_HB1 | STG_TB;
        ratio_full = RATIO_HB1_TB;
      end
      PRIM_HB12_TB:
      begin
        stages     = STG_HB1 | STG_HB2 | STG_TB;
        ratio_full = RATIO_HB12_TB;
      end
      PRIM_HB123_TB:
      begin
        stages     = STG_HB1 | STG_HB2 | STG_HB3 | STG_TB;
        ratio_full = RATIO_HB123_TB;
      end
      default:
      begin
        // Only this branch looks at the secondary selector.
        // Unlisted secondary codes fall back to the longest chain, which is safe for aliasing.
        case (sec_sel)
          SEC_FB_HB1:
          begin
            stages     = STG_FB | STG_HB1;
            ratio_full = RATIO_FB_HB1;
          end
          SEC_FB_HB12:
          begin
            stages     = STG_FB | STG_HB2 | STG_HB1;
            ratio_full = RATIO_FB_HB12;
          end
          SEC_FB_HB123:
          begin
            stages     = STG_FB | STG_HB3 | STG_HB2 | STG_HB1;
            ratio_full = RATIO_FB_HB123;
          end
          default:
          begin
            stages     = STG_TB | STG_HB4 | STG_HB3 | STG_HB2 | STG_HB1;
            ratio_full = RATIO_TB_HB1234;
          end
        endcase
      end
    endcase
  end

  // Complex-to-real conversion halves every ratio.
  assign ratio = c2r_en ? (ratio_full >> 1) : ratio_full;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  assign addr_phase = HSEL && HTRANS[1] && HREADY;

  always_comb
  begin
    if (HADDR == ADDR_PRIMARY)
      ap_sel = SEL_PRIMARY;
    else if (HADDR == ADDR_SECONDARY)
      ap_sel = SEL_SECONDARY;
    else if (HADDR == ADDR_STATUS)
      ap_sel = SEL_STATUS;
    else
      ap_sel = SEL_NONE;
  end

  // A read right behind a write to the same register sees the written value.
  assign prim_view = (st_r.dp_write && st_r.dp_sel == SEL_PRIMARY) ?
                     HWDATA[REG_W-1:0] : st_r.primary;
  assign sec_view  = (st_r.dp_write && st_r.dp_sel == SEL_SECONDARY) ?
                     HWDATA[REG_W-1:0] : st_r.secondary;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.out_valid = 1'b0;

    if (st_r.dp_write && st_r.dp_sel == SEL_PRIMARY)
      st_nxt.primary = HWDATA[REG_W-1:0];
    if (st_r.dp_write && st_r.dp_sel == SEL_SECONDARY)
      st_nxt.secondary = HWDATA[REG_W-1:0];

    if (addr_phase)
    begin
      st_nxt.dp_write = HWRITE;
      st_nxt.dp_sel   = ap_sel;
      st_nxt.rdata    = 32'h0000_0000;
      if (!HWRITE)
      begin
        if (ap_sel == SEL_PRIMARY)
          st_nxt.rdata[REG_W-1:0] = prim_view;
        else if (ap_sel == SEL_SECONDARY)
          st_nxt.rdata[REG_W-1:0] = sec_view;
        else if (ap_sel == SEL_STATUS)
        begin
          st_nxt.rdata[STAT_RATIO_LSB +: RATIO_W] = ratio;
          st_nxt.rdata[STAT_STAGE_LSB +: STAGE_W] = stages;
        end
      end
    end
    else
    begin
      st_nxt.dp_write = 1'b0;
      st_nxt.dp_sel   = SEL_NONE;
    end

    // Comparing with >= keeps the counter safe when the ratio shrinks mid-count.
    if (SAMPLE_VALID)
    begin
      if (st_r.count >= ratio - 6'h01)
      begin
        st_nxt.count     = 6'h00;
        st_nxt.out_valid = 1'b1;
        st_nxt.out_data  = SAMPLE_DATA;
      end
      else
        st_nxt.count = st_r.count + 6'h01;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_r.primary   <= PRIMARY_RESET;
      st_r.secondary <= SECONDARY_RESET;
      st_r.dp_write  <= 1'b0;
      st_r.dp_sel    <= SEL_NONE;
      st_r.rdata     <= 32'h0000_0000;
      st_r.count     <= 6'h00;
      st_r.out_valid <= 1'b0;
      st_r.out_data  <= '0;
    end
    else
      st_r <= st_nxt;
  end

  assign HRDATA       = st_r.rdata;
  assign HREADYOUT    = 1'b1;
  assign HRESP        = 1'b0;
  assign OUT_VALID    = st_r.out_valid;
  assign OUT_DATA     = st_r.out_data;
  assign STAGE_ENABLE = stages;
  assign DECIM_RATIO  = ratio;

endmodule

// [core/ddc_decim_pkg.sv]
// Register map, field layout and decimation chain table of the down-converter rate selector.
package ddc_decim_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam logic [31:0] PRIMARY_IDX     = 32'h0000_0310;
  localparam logic [31:0] SECONDARY_IDX   = 32'h0000_0371;
  localparam logic [31:0] STATUS_IDX      = 32'h0000_0372;
  localparam logic [31:0] WORD_BYTES      = 32'h0000_0004;
  localparam logic [31:0] ADDR_PRIMARY    = PRIMARY_IDX * WORD_BYTES;
  localparam logic [31:0] ADDR_SECONDARY  = SECONDARY_IDX * WORD_BYTES;
  localparam logic [31:0] ADDR_STATUS     = STATUS_IDX * WORD_BYTES;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int          PRIM_SEL_LSB    = 0;
  localparam int          PRIM_SEL_W      = 3;
  localparam int          C2R_BIT         = 3;
  localparam int          SEC_SEL_LSB     = 4;
  localparam int          SEC_SEL_W       = 4;
  localparam int          REG_W           = 8;
  localparam int          RATIO_W         = 6;
  localparam int          STAGE_W         = 6;
  localparam int          STAT_RATIO_LSB  = 0;
  localparam int          STAT_STAGE_LSB  = 8;
  localparam logic [7:0]  PRIMARY_RESET   = 8'h00;
  localparam logic [7:0]  SECONDARY_RESET = 8'h00;

  // ==========================================================================
  // Selector codes
  // ==========================================================================
  localparam logic [2:0]  PRIM_HB12       = 3'h0;
  localparam logic [2:0]  PRIM_HB123      = 3'h1;
  localparam logic [2:0]  PRIM_HB1234     = 3'h2;
  localparam logic [2:0]  PRIM_HB1        = 3'h3;
  localparam logic [2:0]  PRIM_HB1_TB     = 3'h4;
  localparam logic [2:0]  PRIM_HB12_TB    = 3'h5;
  localparam logic [2:0]  PRIM_HB123_TB   = 3'h6;
  localparam logic [2:0]  PRIM_SECONDARY  = 3'h7;
  localparam logic [3:0]  SEC_TB_HB1234   = 4'h0;
  localparam logic [3:0]  SEC_FB_HB1      = 4'h1;
  localparam logic [3:0]  SEC_FB_HB12     = 4'h2;
  localparam logic [3:0]  SEC_FB_HB123    = 4'h3;

  // ==========================================================================
  // Stage enables: bit 0..3 half-band one..four, bit 4 third-band, bit 5 fifth-band
  // ==========================================================================
  typedef logic [STAGE_W-1:0] stage_t;
  localparam stage_t      STG_HB1         = 6'h01;
  localparam stage_t      STG_HB2         = 6'h02;
  localparam stage_t      STG_HB3         = 6'h04;
  localparam stage_t      STG_HB4         = 6'h08;
  localparam stage_t      STG_TB          = 6'h10;
  localparam stage_t      STG_FB          = 6'h20;

  // Ratios with complex-to-real disabled; enabling it halves each one.
  typedef logic [RATIO_W-1:0] ratio_t;
  localparam ratio_t      RATIO_HB12      = 6'h04;
  localparam ratio_t      RATIO_HB123     = 6'h08;
  localparam ratio_t      RATIO_HB1234    = 6'h10;
  localparam ratio_t      RATIO_HB1       = 6'h02;
  localparam ratio_t      RATIO_HB1_TB    = 6'h06;
  localparam ratio_t      RATIO_HB12_TB   = 6'h0C;
  localparam ratio_t      RATIO_HB123_TB  = 6'h18;
  localparam ratio_t      RATIO_TB_HB1234 = 6'h30;
  localparam ratio_t      RATIO_FB_HB1    = 6'h0A;
  localparam ratio_t      RATIO_FB_HB12   = 6'h14;
  localparam ratio_t      RATIO_FB_HB123  = 6'h28;

  typedef enum logic [1:0] {SEL_NONE, SEL_PRIMARY, SEL_SECONDARY, SEL_STATUS} reg_sel_t;

endpackage

// [testbench/ddc_decimation_rate_select_properties.sv]
// Checker tying the resolved ratio, the stage mask and the output pulses together.
`timescale 1ns/1ps

module ddc_decimation_rate_select_checker (
  input  wire logic                              CLK,
  input  wire logic                              NRST,
  input  wire logic                              SAMPLE_VALID,
  input  wire logic                              OUT_VALID,
  input  wire logic [ddc_decim_pkg::STAGE_W-1:0] STAGE_ENABLE,
  input  wire logic [ddc_decim_pkg::RATIO_W-1:0] DECIM_RATIO
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // ==========================================================================
  // Chain against ratio
  // ==========================================================================
  // Each chain except the half-band one-two and one-to-three chains may only carry its real or its complex ratio, never another one.
  hb1_ratio_a: assert property (STAGE_ENABLE == 6'h01 |-> DECIM_RATIO inside {6'h01, 6'h02})
    else $error("ratio wrong for half-band one chain");
  hb1tb_ratio_a: assert property (STAGE_ENABLE == 6'h11 |-> DECIM_RATIO inside {6'h03, 6'h06})
    else $error("ratio wrong for half-band one plus third-band chain");
  hb12tb_ratio_a: assert property (STAGE_ENABLE == 6'h13 |-> DECIM_RATIO inside {6'h06, 6'h0C})
    else $error("ratio wrong for two half-bands plus third-band chain");
  hb123tb_ratio_a: assert property (STAGE_ENABLE == 6'h17 |-> DECIM_RATIO inside {6'h0C, 6'h18})
    else $error("ratio wrong for three half-bands plus third-band chain");
  hb1234_ratio_a: assert property (STAGE_ENABLE == 6'h0F |-> DECIM_RATIO inside {6'h08, 6'h10})
    else $error("ratio wrong for four half-band chain");
  tb_long_a: assert property (STAGE_ENABLE == 6'h1F |-> DECIM_RATIO inside {6'h18, 6'h30})
    else $error("ratio wrong for third-band long chain");
  fb_short_a: assert property (STAGE_ENABLE == 6'h21 |-> DECIM_RATIO inside {6'h05, 6'h0A})
    else $error("ratio wrong for fifth-band short chain");
  fb_mid_a: assert property (STAGE_ENABLE == 6'h23 |-> DECIM_RATIO inside {6'h0A, 6'h14})
    else $error("ratio wrong for fifth-band middle chain");
  fb_long_a: assert property (STAGE_ENABLE == 6'h27 |-> DECIM_RATIO inside {6'h14, 6'h28})
    else $error("ratio wrong for fifth-band long chain");

  // ==========================================================================
  // Output pulses
  // ==========================================================================
  idle_quiet_a: assert property (!SAMPLE_VALID |=> !OUT_VALID)
    else $error("output pulse without an accepted sample");
  unity_pass_a: assert property (SAMPLE_VALID && DECIM_RATIO == 6'h01 |=> OUT_VALID)
    else $error("ratio one did not pass a sample");
endmodule

bind ddc_decimation_rate_select ddc_decimation_rate_select_checker u_chk (
  .CLK          (CLK),
  .NRST         (NRST),
  .SAMPLE_VALID (SAMPLE_VALID),
  .OUT_VALID    (OUT_VALID),
  .STAGE_ENABLE (STAGE_ENABLE),
  .DECIM_RATIO  (DECIM_RATIO)
);

// [testbench/ddc_decimation_rate_select_test.sv]
// Self-checking testbench of the decimation rate selector.
`timescale 1ns/1ps

module ddc_decimation_rate_select_test;
  import ddc_decim_pkg::*;
  logic CLK = 0, NRST = 0, HSEL = 0, HWRITE = 0, SAMPLE_VALID = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd;
  logic [1:0] HTRANS = 0;
  logic [15:0] SAMPLE_DATA = 0, OUT_DATA, last_out;
  logic HREADYOUT, OUT_VALID, HRESP;
  logic [5:0] STAGE_ENABLE, DECIM_RATIO;
  int error_cnt = 0, compares = 0, pulses = 0;

  always #2.5 CLK = ~CLK;

  ddc_decimation_rate_select u_dut (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA(HWDATA),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_DATA(SAMPLE_DATA), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
    .STAGE_ENABLE(STAGE_ENABLE), .DECIM_RATIO(DECIM_RATIO));

  // Pulses are counted at the edge so a one-cycle pulse is never missed.
  always @(posedge CLK)
  begin
    if (OUT_VALID === 1'b1)
    begin
      pulses++;
      last_out = OUT_DATA;
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic end_sim();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      chk("bus timeout", 0, 1);
      end_sim();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    HSEL <= 1;
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= wr;
    wait_ready();
    HSEL <= 0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    wait_ready();
    rd = HRDATA;
    chk("response", 0, {31'h0, HRESP});
    #1;
  endtask

  // Checks ratio and chain once the register write has landed.
  task automatic expect_sel(input logic [5:0] r, input logic [5:0] s);
    chk("ratio", {26'h0, r}, {26'h0, DECIM_RATIO});
    chk("stages", {26'h0, s}, {26'h0, STAGE_ENABLE});
  endtask

  task automatic feed(input int cnt, input int np, input logic [15:0] ld);
    pulses = 0;
    for (int i = 1; i <= cnt; i++)
    begin
      SAMPLE_VALID <= 1;
      SAMPLE_DATA <= 16'(i);
      @(posedge CLK);
    end
    SAMPLE_VALID <= 0;
    repeat (2) @(posedge CLK);
    chk("pulses", np, pulses);
    chk("last output", {16'h0, ld}, {16'h0, last_out});
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    bus(0, ADDR_PRIMARY, 0);
    chk("primary reset", 0, rd);
    bus(0, ADDR_SECONDARY, 0);
    chk("secondary reset", 0, rd);
    bus(1, 32'h0000_0100, 32'hFF);
    bus(0, 32'h0000_0100, 0);
    chk("unmapped", 0, rd);
  endtask

  task automatic t_stream();
    bus(1, ADDR_SECONDARY, 32'h10);
    bus(1, ADDR_PRIMARY, 32'h0F);
    feed(11, 2, 16'h000A);
    bus(1, ADDR_PRIMARY, 32'h0B);
    feed(3, 3, 16'h0003);
  endtask

  task automatic t_primary();
    logic [5:0] r[7] = '{4, 8, 16, 2, 6, 12, 24};
    logic [5:0] s[7] = '{6'h03, 6'h07, 6'h0F, 6'h01, 6'h11, 6'h13, 6'h17};
    for (int c = 0; c < 14; c++)
    begin
      bus(1, ADDR_PRIMARY, 32'(c % 7) | (c / 7 * 8));
      expect_sel(r[c % 7] >> (c / 7), s[c % 7]);
    end
  endtask

  task automatic t_secondary();
    logic [5:0] r[4] = '{48, 10, 20, 40};
    logic [5:0] s[4] = '{6'h1F, 6'h21, 6'h23, 6'h27};
    bus(1, ADDR_PRIMARY, 32'h03);
    bus(1, ADDR_SECONDARY, 32'h30);
    expect_sel(2, 6'h01);
    for (int c = 0; c < 8; c++)
    begin
      bus(1, ADDR_SECONDARY, 32'(c % 4) << 4);
      bus(1, ADDR_PRIMARY, 32'h07 | (c / 4 * 8));
      expect_sel(r[c % 4] >> (c / 4), s[c % 4]);
    end
    bus(0, ADDR_STATUS, 0);
    chk("status", 32'h2714, rd);
  endtask

  initial
  begin
    repeat (6) @(posedge CLK);
    NRST <= 1;
    @(posedge CLK);
    t_reset();
    t_stream();
    t_primary();
    t_secondary();
    end_sim();
  end
endmodule
